//--- pkg/rbs_pkg.sv
package rbs_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned POWER_UP_DELAY_TIMER_MS = 64; // nominal power-up delay
  localparam int unsigned POWER_UP_DELAY_TIMER_CYC = (CLK_HZ / 1000) * POWER_UP_DELAY_TIMER_MS;
  localparam int unsigned FILT_NS = 1000; // brown-out filter time
  localparam int unsigned FILT_CYC = (FILT_NS * 125 + 999) / 1000;
  localparam int unsigned START_CYC = 10; // cycles after pin release
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] FILT_CNT = CNT_W'(FILT_CYC);
  localparam logic [CNT_W-1:0] START_CNT = CNT_W'(START_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  // register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  // brownout_control fields
  localparam int unsigned SWEN_BIT = 7;
  localparam int unsigned FS_BIT = 6;
  localparam int unsigned RDY_BIT = 0;
  localparam logic SWEN_RST = 1'b1;
  localparam logic FS_RST = 1'b0;
  // status register fields
  localparam int unsigned ST_HOLD_BIT = 0;
  localparam int unsigned ST_BOR_BIT = 1;
  localparam int unsigned ST_POWER_UP_DELAY_TIMER_BIT = 2;
  localparam int unsigned ST_ACT_BIT = 3;
  // brownout_mode_select encodings
  localparam logic [1:0] MODE_ON = 2'h3;
  localparam logic [1:0] MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  typedef enum logic [1:0] {ST_HOLD, ST_POWER_UP_DELAY_TIMER, ST_WAIT, ST_RUN} rbs_state_t;
endpackage

//--- core/rbs_top.sv
// Operation
// - any reset source holds device in reset
// - hold reset while power-on detector low
// - power-up delay nominal 64 ms
// - hold reset while power-up delay runs
// - delay enabled when disable_n bit cleared
// - delay starts after power-on and brown-out release
// - two-bit mode field selects brown-out mode
// - brown-out only after filtered low supply
// - modes 11/10 start-up waits ready and supply
// - mode 11 active in sleep, no wake delay
// - mode 10 off in sleep, wake waits ready; sleep only gates the detector here, cpu_run_enable stays set on wake
// - mode 01 start-up waits only with enable set
// - mode 01 follows software enable only
// - execution waits ready when detector forced on
// - forced-on detector ready before cpu runs
// - enable bit 7 resets to 1 on power/brown-out
// - enable bit inert outside mode 01
// - fast-start bit 6 forces band gap
// - fast-start inert in modes 11 and 00
// - ready at bit 0, bits 5..1 zero
// - level select drives analog trip level
// - low-power brown-out ORed into brown-out
// - run ten cycles after pin release
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rbs_top #(
  parameter logic [23:0] POWER_UP_DELAY_TIMER_COUNT = 24'(rbs_pkg::POWER_UP_DELAY_TIMER_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_ok,
  input wire logic brownout_low,
  input wire logic brownout_circuit_ready,
  input wire logic low_power_brownout,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic reset_instr,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic prog_mode_exit,
  input wire logic sleep_mode,
  input wire logic [1:0] brownout_mode_select,
  input wire logic power_up_delay_disable_n,
  input wire logic brownout_level_select,
  output logic device_reset,
  output logic cpu_run_enable,
  output logic brownout_enable,
  output logic bandgap_force_on,
  output logic brownout_level_low,
  output logic brownout_reset_flag
);

  typedef struct packed {
    // sequencer
    rbs_pkg::rbs_state_t state;
    logic [23:0] cnt;
    // supply dip filter
    logic [23:0] filt;
    logic bor;
    // software bits
    logic swen;
    logic fs;
    // bus answer
    logic [31:0] rdata;
    logic ready;
    logic err;
    // output copies
    logic rst;
    logic run;
    logic en;
    logic bg;
    logic lvl;
    logic borf;
  } rbs_regs_t;

  rbs_regs_t s_q;
  rbs_regs_t s_d;

  // decode used for both read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  // detector on for a mode, software enable and sleep state
  function automatic logic mode_active(
    input logic [1:0] m,
    input logic sw,
    input logic slp
  );
    unique case (m)
      rbs_pkg::MODE_ON: mode_active = 1'b1;
      rbs_pkg::MODE_NOSLEEP: mode_active = !slp;
      rbs_pkg::MODE_SW: mode_active = sw;
      rbs_pkg::MODE_OFF: mode_active = 1'b0;
    endcase
  endfunction

  // start after any reset waits for the detector in this mode
  function automatic logic mode_waits(input logic [1:0] m, input logic sw);
    unique case (m)
      rbs_pkg::MODE_ON: mode_waits = 1'b1;
      rbs_pkg::MODE_NOSLEEP: mode_waits = 1'b1;
      rbs_pkg::MODE_SW: mode_waits = sw;
      rbs_pkg::MODE_OFF: mode_waits = 1'b0;
    endcase
  endfunction

  // modes in which the fast-start bit reaches the band gap
  function automatic logic fs_live(input logic [1:0] m);
    unique case (m)
      rbs_pkg::MODE_ON: fs_live = 1'b0;
      rbs_pkg::MODE_NOSLEEP: fs_live = 1'b1;
      rbs_pkg::MODE_SW: fs_live = 1'b1;
      rbs_pkg::MODE_OFF: fs_live = 1'b0;
    endcase
  endfunction

  // reset requests other than supply and programming exit
  localparam int unsigned NSRC = 5;

  logic det_on;
  logic main_bor;
  logic gen_bor;
  logic por_bor;
  logic pwr_hold;
  logic other_src;
  logic wait_rdy;
  logic acc;
  logic wr_done;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_err;
  logic [31:0] rd_word;
  logic [NSRC-1:0] src_vec;
  logic [NSRC-1:0] src_any;
  logic delay_done;
  logic start_done;
  logic start_block;

  // detector enable per mode and sleep
  always_comb begin
    det_on = mode_active(brownout_mode_select, s_q.swen, sleep_mode);
    wait_rdy = mode_waits(brownout_mode_select, s_q.swen);
  end

  // brown-out chain into the power hold
  always_comb begin
    main_bor = s_q.bor && det_on && brownout_circuit_ready;
    gen_bor = main_bor || low_power_brownout;
    por_bor = !power_on_ok || gen_bor;
    pwr_hold = por_bor || prog_mode_exit;
  end

  // collect the remaining reset requests
  assign src_vec = {
    stack_underflow,
    stack_overflow,
    reset_instr,
    watchdog_reset,
    !external_reset_pin_n
  };

  // running or across the request vector
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    if (g == 0) begin : g_first
      assign src_any[g] = src_vec[g];
    end else begin : g_next
      assign src_any[g] = src_any[g - 1] || src_vec[g];
    end
  end

  // any request at all
  assign other_src = src_any[NSRC-1];

  // sequencer compare points
  always_comb begin
    delay_done = (s_q.cnt == POWER_UP_DELAY_TIMER_COUNT - rbs_pkg::CNT_ONE);
    start_done = (s_q.cnt == rbs_pkg::START_CNT - rbs_pkg::CNT_ONE);
    start_block = other_src || (wait_rdy && (!brownout_circuit_ready || brownout_low));
  end

  // bus strobes for the access phase
  always_comb begin
    acc = psel && penable;
    wr_done = acc && s_q.ready && pwrite;
    wr_ctrl = wr_done && hit(paddr, rbs_pkg::ADDR_CTRL) && !pwr_hold;
    wr_stat = wr_done && hit(paddr, rbs_pkg::ADDR_STAT) && !gen_bor;
  end

  // read word for the addressed register
  always_comb begin
    rd_word = 32'h00000000;
    rd_err = 1'b0;
    if (hit(paddr, rbs_pkg::ADDR_CTRL)) begin
      rd_word[rbs_pkg::SWEN_BIT] = s_q.swen;
      rd_word[rbs_pkg::FS_BIT] = s_q.fs;
      rd_word[rbs_pkg::RDY_BIT] = brownout_circuit_ready && det_on;
    end else if (hit(paddr, rbs_pkg::ADDR_STAT)) begin
      rd_word[rbs_pkg::ST_HOLD_BIT] = s_q.rst;
      rd_word[rbs_pkg::ST_BOR_BIT] = s_q.borf;
      rd_word[rbs_pkg::ST_POWER_UP_DELAY_TIMER_BIT] = (s_q.state == rbs_pkg::ST_POWER_UP_DELAY_TIMER);
      rd_word[rbs_pkg::ST_ACT_BIT] = det_on;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_comb begin
    s_d = s_q;
    // supply dip filter
    if (brownout_low && det_on) begin
      if (s_q.filt != rbs_pkg::FILT_CNT) begin
        s_d.filt = s_q.filt + rbs_pkg::CNT_ONE;
      end else begin
        s_d.bor = 1'b1;
      end
    end else begin
      s_d.filt = rbs_pkg::CNT_ZERO;
      s_d.bor = 1'b0;
    end
    // sequencer
    unique case (s_q.state)
      rbs_pkg::ST_HOLD: begin
        if (!pwr_hold) begin
          s_d.cnt = rbs_pkg::CNT_ZERO;
          if (power_up_delay_disable_n) begin
            s_d.state = rbs_pkg::ST_WAIT;
          end else begin
            s_d.state = rbs_pkg::ST_POWER_UP_DELAY_TIMER;
          end
        end
      end
      rbs_pkg::ST_POWER_UP_DELAY_TIMER: begin
        // counts regardless of pin state
        s_d.cnt = s_q.cnt + rbs_pkg::CNT_ONE;
        if (delay_done) begin
          s_d.state = rbs_pkg::ST_WAIT;
          s_d.cnt = rbs_pkg::CNT_ZERO;
        end
      end
      rbs_pkg::ST_WAIT: begin
        if (start_block) begin
          s_d.cnt = rbs_pkg::CNT_ZERO;
        end else if (start_done) begin
          s_d.state = rbs_pkg::ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt + rbs_pkg::CNT_ONE;
        end
      end
      rbs_pkg::ST_RUN: begin
        if (other_src) begin
          s_d.state = rbs_pkg::ST_WAIT;
          s_d.cnt = rbs_pkg::CNT_ZERO;
        end
      end
    endcase
    // supply and programming exit force the hold
    if (pwr_hold) begin
      s_d.state = rbs_pkg::ST_HOLD;
      s_d.swen = rbs_pkg::SWEN_RST;
      s_d.fs = rbs_pkg::FS_RST;
      s_d.cnt = rbs_pkg::CNT_ZERO;
    end
    // sticky brown-out flag
    if (gen_bor) begin
      s_d.borf = 1'b1;
    end
    // apb slave, answer in the first access cycle
    s_d.ready = 1'b0;
    s_d.err = 1'b0;
    s_d.rdata = 32'h00000000;
    if (psel && !penable) begin
      s_d.rdata = rd_word;
      s_d.err = rd_err;
      s_d.ready = 1'b1;
    end else if (acc) begin
      s_d.rdata = s_q.rdata;
      s_d.err = s_q.err;
    end
    if (wr_ctrl) begin
      s_d.swen = pwdata[rbs_pkg::SWEN_BIT];
      s_d.fs = pwdata[rbs_pkg::FS_BIT];
    end
    if (wr_stat) begin
      s_d.borf = s_q.borf && !pwdata[rbs_pkg::ST_BOR_BIT]; // set wins over clear
    end
    // registered outputs
    s_d.rst = (s_d.state != rbs_pkg::ST_RUN);
    s_d.run = (s_d.state == rbs_pkg::ST_RUN);
    s_d.en = det_on;
    s_d.bg = s_q.fs && fs_live(brownout_mode_select);
    s_d.lvl = brownout_level_select;
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.state <= rbs_pkg::ST_HOLD;
      s_q.cnt <= rbs_pkg::CNT_ZERO;
      s_q.filt <= rbs_pkg::CNT_ZERO;
      s_q.bor <= 1'b0;
      s_q.swen <= rbs_pkg::SWEN_RST;
      s_q.fs <= rbs_pkg::FS_RST;
      s_q.rdata <= 32'h00000000;
      s_q.ready <= 1'b0;
      s_q.err <= 1'b0;
      s_q.rst <= 1'b1;
      s_q.run <= 1'b0;
      s_q.en <= 1'b0;
      s_q.bg <= 1'b0;
      s_q.lvl <= 1'b0;
      s_q.borf <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // bus answer
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;

  // sequencer outputs
  assign device_reset = s_q.rst;
  assign cpu_run_enable = s_q.run;

  // detector controls
  assign brownout_enable = s_q.en;
  assign bandgap_force_on = s_q.bg;
  assign brownout_level_low = s_q.lvl;
  assign brownout_reset_flag = s_q.borf;

endmodule // rbs_top
`default_nettype wire

//--- tb/rbs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rbs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_ok,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic sleep_mode,
  input wire logic [1:0] brownout_mode_select,
  input wire logic brownout_level_select,
  input wire logic device_reset,
  input wire logic cpu_run_enable,
  input wire logic brownout_enable,
  input wire logic bandgap_force_on,
  input wire logic brownout_level_low
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // reset hold and release
  AST_RUN_INV:
    assert property (cpu_run_enable != device_reset) else $error("run not inverse");
  AST_POR_HOLD:
    assert property (!power_on_ok |-> ##[1:2] device_reset) else $error("power hold");
  AST_SRC_HOLD:
    assert property (!external_reset_pin_n || watchdog_reset |-> ##[0:2] device_reset)
      else $error("source hold");
  AST_PIN_START:
    assert property ($fell(device_reset) |-> $past(external_reset_pin_n, 10))
      else $error("early start");
  // detector controls
  AST_LEVEL:
    assert property ($past(presetn) |-> brownout_level_low == $past(brownout_level_select))
      else $error("level copy");
  AST_FS_INERT:
    assert property ($past(brownout_mode_select[1] == brownout_mode_select[0])
      |-> !bandgap_force_on) else $error("fast start");
  AST_MODE_OFF:
    assert property ($past(brownout_mode_select == 2'h0) |-> !brownout_enable)
      else $error("mode off");
  AST_SLEEP_OFF:
    assert property ($past(brownout_mode_select == 2'h2 && sleep_mode) |-> !brownout_enable)
      else $error("sleep off");
  AST_MODE_ON:
    assert property ($past(brownout_mode_select == 2'h3 && power_on_ok && presetn)
      |-> brownout_enable) else $error("mode on");
endmodule // rbs_properties
`default_nettype wire

//--- tb/test_rbs_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_rbs_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic pready, pslverr, er, device_reset, cpu_run_enable, brownout_enable;
  logic bandgap_force_on, brownout_level_low, brownout_reset_flag;
  logic power_on_ok = 0, brownout_low = 0, brownout_circuit_ready = 0, sleep_mode = 0;
  logic power_up_delay_disable_n = 1, brownout_level_select = 0;
  logic [1:0] brownout_mode_select = 2'h0;
  logic [6:0] src = 7'h00;
  logic low_power_brownout, external_reset_pin_n, watchdog_reset, reset_instr;
  logic stack_overflow, stack_underflow, prog_mode_exit;
  int err_count = 0, checks = 0, seed = 75;
  // reset sources from one vector
  assign {external_reset_pin_n, prog_mode_exit, low_power_brownout, stack_underflow,
    stack_overflow, reset_instr, watchdog_reset} = src ^ 7'h40;
  always #4 pclk = ~pclk;
  rbs_top #(.POWER_UP_DELAY_TIMER_COUNT(24'h000064)) uut (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one bus transfer, answer left in rd and er
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(negedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pwr_cycle;
    power_on_ok <= 1'b0;
    cyc(3);
    power_on_ok <= 1'b1;
    cyc(150);
  endtask
  function automatic logic act(input logic [1:0] m, input logic sw, input logic slp);
    return m == 2'h3 || (m == 2'h2 && !slp) || (m == 2'h1 && sw);
  endfunction
  task automatic tally_and_finish;
    $display("mismatches=%0d comparisons=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    cyc(20000);
    err_count++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    cyc(6);
    presetn <= 1'b1;
    power_on_ok <= 1'b1;
    cyc(20);
    `CHK(device_reset, 1'b0)
    apb(1'b0, rbs_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h00000080)
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      brownout_mode_select <= d[9:8];
      brownout_circuit_ready <= d[10];
      sleep_mode <= d[11];
      brownout_level_select <= d[12];
      apb(1'b1, rbs_pkg::ADDR_CTRL, d);
      apb(1'b0, rbs_pkg::ADDR_CTRL, 32'h0);
      `CHK(rd, {24'h0, d[7:6], 5'h00, d[10] & act(d[9:8], d[7], d[11])})
      `CHK(brownout_enable, act(d[9:8], d[7], d[11]))
      `CHK(bandgap_force_on, d[6] & (d[9] ^ d[8]))
    end
    apb(1'b0, 12'h008, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    brownout_mode_select <= 2'h0;
    sleep_mode <= 1'b0;
    power_up_delay_disable_n <= 1'b0;
    apb(1'b1, rbs_pkg::ADDR_CTRL, 32'h40);
    for (int i = 0; i < 7; i++) begin
      src <= 7'h01 << i;
      cyc(3);
      `CHK(device_reset, 1'b1)
      src <= 7'h00;
      if (i == 4 || i == 5) begin
        `CHK(brownout_reset_flag, i == 4)
        cyc(90);
        `CHK(device_reset, 1'b1)
        cyc(35);
      end else cyc(15);
      `CHK(device_reset, 1'b0)
      apb(1'b0, rbs_pkg::ADDR_CTRL, 32'h0);
      if (i < 4) `CHK(rd, 32'h00000040)
      if (i == 4) apb(1'b1, rbs_pkg::ADDR_STAT, 32'h2);
    end
    apb(1'b1, rbs_pkg::ADDR_STAT, 32'h2);
    // pin held low across the power-up delay
    src <= 7'h40;
    brownout_mode_select <= 2'h3;
    brownout_circuit_ready <= 1'b0;
    pwr_cycle;
    src <= 7'h00;
    cyc(8);
    `CHK(device_reset, 1'b1)
    cyc(6);
    `CHK(device_reset, 1'b1)
    brownout_circuit_ready <= 1'b1;
    cyc(14);
    `CHK({device_reset, brownout_reset_flag}, 2'b00)
    brownout_low <= 1'b1;
    cyc(100);
    brownout_low <= 1'b0;
    cyc(3);
    `CHK({device_reset, brownout_reset_flag}, 2'b00)
    brownout_low <= 1'b1;
    cyc(140);
    `CHK({device_reset, brownout_reset_flag}, 2'b11)
    tally_and_finish;
  end
endmodule // test_rbs_top
bind rbs_top rbs_properties chk (
  .pclk(pclk),
  .presetn(presetn),
  .power_on_ok(power_on_ok),
  .external_reset_pin_n(external_reset_pin_n),
  .watchdog_reset(watchdog_reset),
  .sleep_mode(sleep_mode),
  .brownout_mode_select(brownout_mode_select),
  .brownout_level_select(brownout_level_select),
  .device_reset(device_reset),
  .cpu_run_enable(cpu_run_enable),
  .brownout_enable(brownout_enable),
  .bandgap_force_on(bandgap_force_on),
  .brownout_level_low(brownout_level_low)
);
`default_nettype wire
